// ### verilog/spibf_pkg.sv
package spibf_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses inside the block window)
  // ---------------------------------------------------------------
  localparam logic [7:0] SPIBF_OFS_CTRL1 = 8'h00;
  localparam logic [7:0] SPIBF_OFS_CTRL2 = 8'h04;
  localparam logic [7:0] SPIBF_OFS_RATE  = 8'h08;
  localparam logic [7:0] SPIBF_OFS_STAT  = 8'h0C;
  localparam logic [7:0] SPIBF_OFS_DATA  = 8'h10;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SPIBF_BIT_RXIE = 7;
  localparam int SPIBF_BIT_EN   = 6;
  localparam int SPIBF_BIT_TXIE = 5;
  localparam int SPIBF_BIT_MASTER_SELECT = 4;
  localparam int SPIBF_BIT_SELECT_OUTPUT_ENABLE = 1;
  localparam int SPIBF_BIT_FDEN = 4;
  localparam int SPIBF_BIT_RXF  = 7;
  localparam int SPIBF_BIT_TXE  = 5;
  localparam int SPIBF_BIT_MASTER_FAULT_FLAG = 4;
  localparam int SPIBF_PRE_HI   = 6;
  localparam int SPIBF_PRE_LO   = 4;
  localparam int SPIBF_RATE_HI  = 2;
  localparam int SPIBF_RATE_LO  = 0;

  // ---------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] SPIBF_RST_CTRL1  = 8'h00;
  localparam logic [7:0] SPIBF_RST_CTRL2  = 8'h00;
  localparam logic [7:0] SPIBF_RST_RATE   = 8'h00;
  localparam logic       SPIBF_RST_TXE    = 1'b1;
  localparam logic [7:0] SPIBF_MASK_CTRL2 = 8'h1B;
  localparam logic [7:0] SPIBF_MASK_RATE  = 8'h77;

  // ---------------------------------------------------------------
  // frame timing
  // ---------------------------------------------------------------
  localparam logic [4:0] SPIBF_LAST_EDGE = 5'h0F;

  typedef enum logic [0:0] {SPIBF_SH_IDLE, SPIBF_SH_RUN} spibf_shift_state_type;

  // status byte: only bits 7, 5 and 4 exist, the rest read zero
  function automatic logic [7:0] spibf_status_byte(input logic rxf,
                                                   input logic txe,
                                                   input logic mf);
    logic [7:0] b;
    b = 8'h00;
    b[SPIBF_BIT_RXF] = rxf;
    b[SPIBF_BIT_TXE] = txe;
    b[SPIBF_BIT_MASTER_FAULT_FLAG] = mf;
    return b;
  endfunction : spibf_status_byte

endpackage : spibf_pkg

// ### verilog/spibf_if.sv
`timescale 1ns/1ps
`default_nettype none

interface spibf_rate_if;
  logic       run;
  logic [2:0] pre;
  logic [2:0] rate;
  logic       half_tick;
  modport baud (input run, input pre, input rate, output half_tick);
  modport ctl  (output run, output pre, output rate, input half_tick);
endinterface : spibf_rate_if

interface spibf_shift_if;
  logic       load;
  logic [7:0] tx_byte;
  logic       abort;
  logic       half_tick;
  logic       busy;
  logic       done;
  logic [7:0] rx_byte;
  modport shifter (input load, input tx_byte, input abort, input half_tick,
                   output busy, output done, output rx_byte);
  modport ctl     (output load, output tx_byte, output abort, output half_tick,
                   input busy, input done, input rx_byte);
endinterface : spibf_shift_if

`default_nettype wire

// ### verilog/spibf_baud.sv
`timescale 1ns/1ps
`default_nettype none

module spibf_baud
  import spibf_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   rst_n,
  spibf_rate_if.baud  rate_io
);

  typedef struct packed {
    logic [2:0] pre_cnt;
    logic [7:0] div_cnt;
    logic [5:0] cfg;
    logic       half_tick;
  } spibf_baud_state_type;

  spibf_baud_state_type state;
  spibf_baud_state_type next_state;
  logic                 restart;
  logic                 pre_tick;
  logic [7:0]           half_last;

  always_comb begin
    next_state = state;
    next_state.cfg = {rate_io.pre, rate_io.rate};
    // a new setting restarts the chain so no half period mixes two ratios
    restart = !rate_io.run || (state.cfg != {rate_io.pre, rate_io.rate});
    pre_tick = (state.pre_cnt == rate_io.pre); // R1 R2
    half_last = (8'h01 << rate_io.rate) - 8'h01; // R3
    next_state.half_tick = 1'b0;
    if (restart) begin
      next_state.pre_cnt = 3'h0;
      next_state.div_cnt = 8'h00;
    end else if (pre_tick) begin
      next_state.pre_cnt = 3'h0;
      if (state.div_cnt == half_last) begin
        next_state.div_cnt = 8'h00;
        next_state.half_tick = 1'b1; // R4 R21
      end else begin
        next_state.div_cnt = state.div_cnt + 8'h01;
      end
    end else begin
      next_state.pre_cnt = state.pre_cnt + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rate_io.half_tick = state.half_tick;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [11:0] gap;
  logic [11:0] half_len;

  assign half_len = 12'({1'b0, rate_io.pre} + 4'h1) << rate_io.rate;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 12'h000;
    end else if (restart) begin
      gap <= 12'h000;
    end else if (state.half_tick) begin
      gap <= 12'h001;
    end else begin
      gap <= gap + 12'h001;
    end
  end

  a_half_period_len: assert property (@(posedge mclk) disable iff (!rst_n) // R21
    state.half_tick && !restart |-> gap == half_len)
    else $error("half bit period does not match prescale times divider");

endmodule : spibf_baud

`default_nettype wire

// ### verilog/spibf_shift.sv
`timescale 1ns/1ps
`default_nettype none

module spibf_shift
  import spibf_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     rst_n,
  spibf_shift_if.shifter sh_io,
  input  wire logic     miso,
  output logic          sclk,
  output logic          mosi
);

  typedef struct packed {
    spibf_shift_state_type st;
    logic [7:0]            sh;
    logic [4:0]            edges;
    logic                  samp;
    logic                  sclk;
    logic                  mosi;
    logic                  done;
    logic [7:0]            rx;
  } spibf_shift_reg_type;

  spibf_shift_reg_type state;
  spibf_shift_reg_type next_state;

  // clock idles low, data sampled on rising and shifted on falling edge
  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    if (sh_io.abort) begin
      next_state.st = SPIBF_SH_IDLE;
      next_state.sclk = 1'b0;
      next_state.edges = 5'h00;
    end else begin
      unique case (state.st)
        SPIBF_SH_IDLE: begin
          if (sh_io.load) begin
            next_state.st = SPIBF_SH_RUN;
            next_state.sh = sh_io.tx_byte;
            next_state.mosi = sh_io.tx_byte[7];
            next_state.edges = 5'h00;
          end
        end
        SPIBF_SH_RUN: begin
          if (sh_io.half_tick) begin
            next_state.sclk = !state.sclk;
            next_state.edges = state.edges + 5'h01;
            if (!state.sclk) begin
              next_state.samp = miso;
            end else begin
              next_state.sh = {state.sh[6:0], state.samp};
              next_state.mosi = state.sh[6];
            end
            if (state.edges == SPIBF_LAST_EDGE) begin
              next_state.st = SPIBF_SH_IDLE;
              next_state.done = 1'b1;
              next_state.rx = {state.sh[6:0], state.samp};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sh_io.busy = (state.st == SPIBF_SH_RUN);
  assign sh_io.done = state.done;
  assign sh_io.rx_byte = state.rx;
  assign sclk = state.sclk;
  assign mosi = state.mosi;

  a_frame_sixteen: assert property (@(posedge mclk) disable iff (!rst_n) // R7
    state.done |-> $past(state.edges) == SPIBF_LAST_EDGE && !state.sclk)
    else $error("frame ended after a wrong number of clock edges");

endmodule : spibf_shift

`default_nettype wire

// ### verilog/spibf_top.sv
// Functional notes
// (R1) prescale field gives ratio field plus one
// (R2) prescaler runs on bus clock, feeds divider
// (R3) divider ratio is two to field plus one
// (R4) divider output is master bit clock
// (R5) bit rate register accessible at any time
// (R6) status keeps bits 7,5,4; writes ignored
// (R7) receive full set when transfer completes
// (R8) receive full cleared: status read, data read
// (R9) transmit empty set when byte enters shifter
// (R10) transmit empty cleared: status read, data write
// (R11) data write without armed status read ignored
// (R12) transmit irq while empty flag and enable
// (R13) idle write moves at once, flag back fast
// (R14) after shift, queued byte moves, else nothing
// (R15) master fault set by low select input
// (R16) fault only if master, detect on, no output
// (R17) fault cleared: status read, control one write
// (R18) one enable gates receive and fault irqs
// (R19) disable aborts, clears receive, sets empty
// (R20) master write starts transfer when shifter free
// (R21) bit clock equals bus over prescale times divider
`timescale 1ns/1ps
`default_nettype none

module spibf_top
  import spibf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        miso,
  input  wire logic        ss_in_n,
  output logic             sclk,
  output logic             mosi,
  output logic             ss_out_n,
  output logic             ss_oe_n,
  output logic             tx_irq,
  output logic             rx_fault_irq
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic       rst_n;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [7:0]  rate;
    logic [7:0]  txbuf;
    logic        txbuf_valid;
    logic [7:0]  rxbuf;
    logic        rx_full;
    logic        tx_empty;
    logic        master_fault_flag;
    logic        rx_arm;
    logic        tx_arm;
    logic        mf_arm;
    logic        wr_pend;
    logic [7:0]  wr_ofs;
    logic [31:0] hrdata;
    logic        hready_o;
    logic        load;
    logic        tx_irq;
    logic        rxf_irq;
    logic        ss_out_n;
    logic        ss_oe_n;
  } spibf_top_state_type;

  spibf_top_state_type state;
  spibf_top_state_type next_state;

  spibf_rate_if  rate_bus ();
  spibf_shift_if shift_bus ();

  spibf_baud u_baud (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .rate_io (rate_bus.baud)
  );

  spibf_shift u_shift (
    .mclk  (mclk),
    .rst_n (rst_n),
    .sh_io (shift_bus.shifter),
    .miso  (miso),
    .sclk  (sclk),
    .mosi  (mosi)
  );

  // the divider only runs while a frame is being shifted
  assign rate_bus.run = shift_bus.busy;
  assign rate_bus.pre = state.rate[SPIBF_PRE_HI:SPIBF_PRE_LO]; // R1
  assign rate_bus.rate = state.rate[SPIBF_RATE_HI:SPIBF_RATE_LO]; // R3
  assign shift_bus.half_tick = rate_bus.half_tick;
  assign shift_bus.load = state.load;
  assign shift_bus.tx_byte = state.txbuf;
  assign shift_bus.abort = !state.ctrl1[SPIBF_BIT_EN]; // R19

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic       addr_ok;
  logic       rd_now;
  logic [7:0] a_ofs;
  logic       enabled;
  logic       is_master;
  logic       fault_input;
  logic       ss_drive;
  logic       rx_clear;
  logic       start_move;

  always_comb begin
    next_state = state;
    // haddr above bit 7 is not decoded, so the block aliases in its window
    a_ofs = haddr[7:0];
    addr_ok = hsel && htrans[1] && hready;
    rd_now = addr_ok && !hwrite;
    enabled = state.ctrl1[SPIBF_BIT_EN];
    is_master = state.ctrl1[SPIBF_BIT_MASTER_SELECT];
    fault_input = is_master && state.ctrl2[SPIBF_BIT_FDEN]
                  && !state.ctrl1[SPIBF_BIT_SELECT_OUTPUT_ENABLE]; // R16
    ss_drive = is_master && state.ctrl2[SPIBF_BIT_FDEN]
               && state.ctrl1[SPIBF_BIT_SELECT_OUTPUT_ENABLE];
    rx_clear = 1'b0;
    next_state.load = 1'b0;
    next_state.hready_o = 1'b1;
    next_state.wr_pend = addr_ok && hwrite;
    next_state.wr_ofs = a_ofs;

    // read data is registered in the address phase, zero wait states
    if (rd_now) begin
      unique case (a_ofs)
        SPIBF_OFS_CTRL1: next_state.hrdata = {24'h000000, state.ctrl1};
        SPIBF_OFS_CTRL2: next_state.hrdata = {24'h000000, state.ctrl2};
        SPIBF_OFS_RATE:  next_state.hrdata = {24'h000000, state.rate}; // R5
        SPIBF_OFS_STAT:  next_state.hrdata = {24'h000000,
                           spibf_status_byte(state.rx_full, state.tx_empty, state.master_fault_flag)}; // R6
        SPIBF_OFS_DATA:  next_state.hrdata = {24'h000000, state.rxbuf};
        default:         next_state.hrdata = 32'h00000000;
      endcase
      if (a_ofs == SPIBF_OFS_STAT) begin
        next_state.rx_arm = state.rx_full; // R8
        next_state.tx_arm = state.tx_empty; // R10
        next_state.mf_arm = state.master_fault_flag; // R17
      end
      if (a_ofs == SPIBF_OFS_DATA && state.rx_arm && state.rx_full) begin
        rx_clear = 1'b1;
        next_state.rx_full = 1'b0; // R8
        next_state.rx_arm = 1'b0;
      end
    end

    // write data phase; a status write falls to default and does nothing
    if (state.wr_pend) begin
      unique case (state.wr_ofs)
        SPIBF_OFS_CTRL1: begin
          next_state.ctrl1 = hwdata[7:0];
          if (state.mf_arm && state.master_fault_flag) begin
            next_state.master_fault_flag = 1'b0; // R17
          end
          next_state.mf_arm = 1'b0;
        end
        SPIBF_OFS_CTRL2: next_state.ctrl2 = hwdata[7:0] & SPIBF_MASK_CTRL2;
        SPIBF_OFS_RATE:  next_state.rate = hwdata[7:0] & SPIBF_MASK_RATE; // R5
        SPIBF_OFS_DATA: begin
          if (state.tx_arm && state.tx_empty) begin
            next_state.txbuf = hwdata[7:0]; // R11
            next_state.txbuf_valid = 1'b1;
            next_state.tx_empty = 1'b0; // R10
            next_state.tx_arm = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // buffer to shifter; hardware sets below win over software clears
    start_move = state.txbuf_valid && !shift_bus.busy && !state.load
                 && is_master && enabled;
    if (start_move) begin
      next_state.load = 1'b1; // R20 R13 R14
      next_state.txbuf_valid = 1'b0;
      next_state.tx_empty = 1'b1; // R9
    end
    if (shift_bus.done) begin
      // a full buffer that is not being emptied keeps the old byte
      if (!state.rx_full || rx_clear) begin
        next_state.rxbuf = shift_bus.rx_byte;
      end
      next_state.rx_full = 1'b1; // R7
    end
    if (enabled && fault_input && !ss_in_n) begin
      next_state.master_fault_flag = 1'b1; // R15 R16
    end
    if (!enabled) begin
      next_state.rx_full = 1'b0; // R19
      next_state.tx_empty = 1'b1;
      next_state.txbuf_valid = 1'b0;
      next_state.load = 1'b0;
      next_state.rx_arm = 1'b0;
    end

    // irq lines follow the next flag values so they line up with the flags
    next_state.tx_irq = next_state.tx_empty && next_state.ctrl1[SPIBF_BIT_TXIE]; // R12
    next_state.rxf_irq = (next_state.rx_full || next_state.master_fault_flag)
                         && next_state.ctrl1[SPIBF_BIT_RXIE]; // R18
    next_state.ss_oe_n = !ss_drive;
    next_state.ss_out_n = !(ss_drive && (shift_bus.busy || next_state.load));
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.ctrl1 <= SPIBF_RST_CTRL1;
      state.ctrl2 <= SPIBF_RST_CTRL2;
      state.rate <= SPIBF_RST_RATE;
      state.tx_empty <= SPIBF_RST_TXE;
      state.hready_o <= 1'b1;
      state.ss_out_n <= 1'b1;
      state.ss_oe_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign hreadyout = state.hready_o;
  assign hresp = 1'b0;
  assign hrdata = state.hrdata;
  assign ss_out_n = state.ss_out_n;
  assign ss_oe_n = state.ss_oe_n;
  assign tx_irq = state.tx_irq;
  assign rx_fault_irq = state.rxf_irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_idle_write;
    state.wr_pend && state.wr_ofs == SPIBF_OFS_DATA && state.tx_arm && state.tx_empty
    && !state.txbuf_valid && !shift_bus.busy && !state.load
    && state.ctrl1[SPIBF_BIT_MASTER_SELECT] && state.ctrl1[SPIBF_BIT_EN];
  endsequence

  sequence s_refill;
    !state.tx_empty && state.txbuf_valid ##1 state.tx_empty && state.load;
  endsequence

  a_rx_set_done: assert property ( // R7
    shift_bus.done |=> state.rx_full || !state.ctrl1[SPIBF_BIT_EN])
    else $error("receive full not set after transfer end");

  a_rx_clear_seq: assert property ( // R8
    $fell(state.rx_full) |-> $past(state.rx_arm) || !state.ctrl1[SPIBF_BIT_EN])
    else $error("receive full cleared without status read");

  a_tx_write_gate: assert property ( // R11
    state.wr_pend && state.wr_ofs == SPIBF_OFS_DATA && !(state.tx_arm && state.tx_empty)
    |=> $stable(state.txbuf) && $stable(state.txbuf_valid))
    else $error("data write taken without armed status read");

  a_tx_idle_refill: assert property ( // R13
    s_idle_write |=> s_refill)
    else $error("idle write did not reach shifter within two cycles");

  a_fault_gated: assert property ( // R16
    $rose(state.master_fault_flag) |-> $past(fault_input && state.ctrl1[SPIBF_BIT_EN]))
    else $error("master fault set outside fault input mode");

  a_fault_clear_seq: assert property ( // R17
    $fell(state.master_fault_flag) |-> $past(state.mf_arm && state.wr_pend
                                && state.wr_ofs == SPIBF_OFS_CTRL1))
    else $error("master fault cleared without the clear sequence");

  a_disable_flush: assert property ( // R19
    !state.ctrl1[SPIBF_BIT_EN] |=> !state.rx_full && state.tx_empty && !shift_bus.busy)
    else $error("disable left data or transfer behind");

  a_load_starts: assert property ( // R20
    state.load |=> shift_bus.busy ##1 !state.ss_out_n || state.ss_oe_n)
    else $error("buffered byte did not start a transfer");

  a_status_write: assert property ( // R6
    state.wr_pend && state.wr_ofs == SPIBF_OFS_STAT && !shift_bus.done && !start_move
    && state.ctrl1[SPIBF_BIT_EN] && !fault_input
    |=> $stable(state.rx_full) && $stable(state.tx_empty) && $stable(state.master_fault_flag))
    else $error("status write changed a flag");

  // follow-up checks on flags, interrupt lines and the first data bit
  a_tx_irq_level: assert property ( // R12
    state.tx_irq == (state.tx_empty && state.ctrl1[SPIBF_BIT_TXIE]))
    else $error("transmit irq does not follow its flag and enable");

  a_rx_irq_level: assert property ( // R18
    state.rxf_irq == ((state.rx_full || state.master_fault_flag) && state.ctrl1[SPIBF_BIT_RXIE]))
    else $error("receive or fault irq does not follow its flags and enable");

  a_fault_sets: assert property ( // R15
    enabled && fault_input && !ss_in_n |=> state.master_fault_flag)
    else $error("low select input in fault mode did not set the fault flag");

  a_refill_after_frame: assert property ( // R14
    shift_bus.done && state.txbuf_valid && enabled && is_master |=> state.load && state.tx_empty)
    else $error("queued byte did not move at frame end");

  a_idle_no_load: assert property ( // R14
    shift_bus.done && !state.txbuf_valid |=> !state.load)
    else $error("shifter loaded with no queued byte");

  a_status_pad_zero: assert property ( // R6
    rd_now && a_ofs == SPIBF_OFS_STAT |=> (hrdata & 32'hFFFFFF4F) == 32'h00000000)
    else $error("unimplemented status bit read as one");

  a_mosi_first_bit: assert property ( // R20
    state.load |=> mosi == $past(state.txbuf[7]))
    else $error("first data bit is not the buffered msb");

endmodule : spibf_top

`default_nettype wire

// ### bench/spibf_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// serial slave: mode 0, msb first
// ---------------------------------------------------------------
// miso flips when released so a stale bit never looks valid
module spibf_slave_model (
  input  wire logic       sclk,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic [7:0]      got
);
  logic [7:0] sh;
  int         nbit;
  initial begin
    miso = 1'h0;
    got  = 8'h00;
    sh   = 8'h00;
    nbit = 0;
  end
  always @(negedge ss_n) begin
    sh   = reply;
    miso = reply[7];
    nbit = 0;
  end
  always @(posedge ss_n) miso = ~miso;
  always @(posedge sclk) begin
    got  = {got[6:0], mosi};
    nbit = nbit + 1;
  end
  // reload after a whole byte: back-to-back frames may keep select low
  always @(negedge sclk) begin
    if (nbit == 8) begin
      sh   = reply;
      nbit = 0;
    end else sh = {sh[6:0], 1'h0};
    miso = sh[7];
  end
endmodule : spibf_slave_model

`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import spibf_pkg::*;
;
  logic        mclk, rstn, hsel, hwrite, ss_ext, miso, hreadyout, hresp, sclk, mosi;
  logic        ss_out_n, ss_oe_n, tx_irq, rx_fault_irq, ss_pin;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  reply, got;
  int          n_errors, checks, cyc;

  // the select pin is shared: the design drives it only while its enable is low
  assign ss_pin = ss_oe_n ? ss_ext : ss_out_n;

  spibf_top dut (.mclk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .miso, .ss_in_n(ss_pin), .sclk,
    .mosi, .ss_out_n, .ss_oe_n, .tx_irq, .rx_fault_irq);
  spibf_slave_model slave (.sclk, .ss_n(ss_pin), .mosi, .reply, .miso, .got);

  // ---------------------------------------------------------------
  // bus master and checking
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    rd = hrdata;
    // idle cycle: a read address phase must not meet a write data phase
    @(posedge mclk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(1'h1, a, v, d);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'h0, a, 32'h0, d);
    chk(what, exp, d);
  endtask : rdc

  task automatic poll_rx;
    logic [31:0] d;
    do bus(1'h0, SPIBF_OFS_STAT, 32'h0, d); while (d[7] !== 1'h1);
  endtask : poll_rx

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic rise(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (sclk !== 1'h0);
    do begin
      @(posedge mclk);
      n++;
    end while (sclk !== 1'h1);
  endtask : rise

  task automatic frame(input logic [2:0] p, input logic [2:0] r, input logic [7:0] tx,
                       input logic [7:0] rp);
    int n;
    wr(SPIBF_OFS_RATE, {25'h0, p, 1'h0, r});
    reply <= rp;
    rdc("status armed", SPIBF_OFS_STAT, 32'h20);
    wr(SPIBF_OFS_DATA, {24'h0, tx});
    rise(n);
    rise(n);
    chk("sclk period", 32'((32'h1 + p) << (32'h1 + r)), 32'(n));
    poll_rx();
    rdc("rx data", SPIBF_OFS_DATA, {24'h0, rp});
    chk("mosi byte", {24'h0, tx}, {24'h0, got});
    rdc("rx cleared", SPIBF_OFS_STAT, 32'h20);
  endtask : frame

  always #5 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {mclk, rstn, hsel, hwrite, haddr, htrans, hwdata, reply} = '0;
    {n_errors, checks, cyc} = '0;
    hsize  = 3'h2;
    ss_ext = 1'h1;
    repeat (3) @(posedge mclk);
    rstn <= 1'h1;
    tick(3);
    rdc("status reset", SPIBF_OFS_STAT, 32'h20);
    rdc("rate reset", SPIBF_OFS_RATE, 32'h0);
    wr(SPIBF_OFS_STAT, 32'hFF);
    rdc("status read only", SPIBF_OFS_STAT, 32'h20);
    wr(SPIBF_OFS_RATE, 32'hFF);
    rdc("rate rw", SPIBF_OFS_RATE, 32'h77);
    rdc("unmapped", 8'h14, 32'h0);
    chk("hresp okay", 32'h0, {31'h0, hresp});
    // use up the status read while disabled so the next data write is unarmed
    wr(SPIBF_OFS_DATA, 32'hA5);
    wr(SPIBF_OFS_CTRL2, 32'h10);
    wr(SPIBF_OFS_CTRL1, 32'h52);
    wr(SPIBF_OFS_DATA, 32'h5A);
    tick(4);
    chk("unarmed write", 32'h1, {31'h0, ss_out_n});
    chk("select driven", 32'h0, {31'h0, ss_oe_n});
    chk("tx irq off", 32'h0, {31'h0, tx_irq});
    wr(SPIBF_OFS_CTRL1, 32'h72);
    tick(2);
    chk("tx irq on", 32'h1, {31'h0, tx_irq});
    for (int i = 0; i < 8; i++) frame(3'(i), 3'(7 - i), 8'hA5 ^ 8'(i), 8'h3C + 8'(i));
    // double buffering: second byte queued during the first frame
    wr(SPIBF_OFS_RATE, 32'h33);
    reply <= 8'hC3;
    rdc("status armed", SPIBF_OFS_STAT, 32'h20);
    wr(SPIBF_OFS_DATA, 32'h81);
    rdc("empty refilled", SPIBF_OFS_STAT, 32'h20);
    wr(SPIBF_OFS_DATA, 32'h42);
    rdc("empty cleared", SPIBF_OFS_STAT, 32'h0);
    chk("tx irq gated", 32'h0, {31'h0, tx_irq});
    wr(SPIBF_OFS_RATE, 32'h33);
    rdc("rate in frame", SPIBF_OFS_RATE, 32'h33);
    reply <= 8'h96;
    poll_rx();
    rdc("both flags", SPIBF_OFS_STAT, 32'hA0);
    rdc("first rx", SPIBF_OFS_DATA, 32'hC3);
    poll_rx();
    rdc("second rx", SPIBF_OFS_DATA, 32'h96);
    chk("second mosi", 32'h42, {24'h0, got});
    // disable in mid-frame with the receive flag still set
    rdc("status armed", SPIBF_OFS_STAT, 32'h20);
    wr(SPIBF_OFS_DATA, 32'h11);
    poll_rx();
    wr(SPIBF_OFS_DATA, 32'h22);
    tick(20);
    wr(SPIBF_OFS_CTRL1, 32'h32);
    rdc("disable flush", SPIBF_OFS_STAT, 32'h20);
    // settings where a low select must not raise a fault
    for (int i = 0; i < 3; i++) begin
      wr(SPIBF_OFS_CTRL2, i == 0 ? 32'h0 : 32'h10);
      wr(SPIBF_OFS_CTRL1, i == 1 ? 32'h52 : (i == 2 ? 32'h40 : 32'h50));
      ss_ext <= 1'h0;
      tick(4);
      rdc("no fault", SPIBF_OFS_STAT, 32'h20);
      ss_ext <= 1'h1;
    end
    wr(SPIBF_OFS_CTRL2, 32'h10);
    wr(SPIBF_OFS_CTRL1, 32'h50);
    ss_ext <= 1'h0;
    tick(3);
    ss_ext <= 1'h1;
    tick(2);
    chk("fault irq masked", 32'h0, {31'h0, rx_fault_irq});
    wr(SPIBF_OFS_CTRL1, 32'hD0);
    tick(2);
    chk("fault irq", 32'h1, {31'h0, rx_fault_irq});
    rdc("fault set", SPIBF_OFS_STAT, 32'h30);
    wr(SPIBF_OFS_CTRL1, 32'hD0);
    rdc("fault cleared", SPIBF_OFS_STAT, 32'h20);
    summarize();
  end
endmodule : tb_top

`default_nettype wire
